// File: shared/lgc_pkg.sv
package lgc_pkg;
  // array dimensions
  localparam int NUM_OUT_CELLS = 16;
  localparam int NUM_IN_CELLS = 20;
  localparam int MAX_PRODUCT_TERMS = 137;
  localparam int BANK_WIDTH = 8;
  // native and borrowable product terms per cell
  localparam int FIRST_NATIVE_TERMS = 3;
  localparam int FIRST_BORROW_TERMS = 6;
  localparam int SECOND_NATIVE_TERMS = 4;
  localparam int SECOND_LOW_BORROW_TERMS = 5;
  localparam int SECOND_HIGH_BORROW_TERMS = 6;
  // cells of a bank that borrow the low count
  localparam int SECOND_LOW_CELLS = 4;
  // widest cell sum: native plus borrowed
  localparam int MAX_CELL_TERMS = 10;
  // second-bank cells barred from port c (test access pins)
  localparam logic [7:0] PORT_C_BARRED = 8'h63;
  // reset values
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic CELL_RESET = 1'b0;
  // flip-flop personality
  typedef enum logic [1:0] {
    LGC_FF_D,
    LGC_FF_T,
    LGC_FF_JK,
    LGC_FF_SR
  } lgc_ff_type;
endpackage : lgc_pkg

// File: core/lgc_cell_ff.sv
`timescale 1ns/1ps
// one output cell storage element: edge-clocked on its own selected clock,
// with level preset/clear and an asynchronous processor load that wins over both
module lgc_cell_ff
  import lgc_pkg::*;
(
  // clock and controls
  input wire logic cell_clk_i,
  input wire logic nrst_i,
  input wire logic preset_i,
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic load_data_i,
  input wire logic next_i,
  // state
  output logic q_o
);
  // async terms merged: load first, then preset, then clear
  logic set_n;
  logic rst_n;
  assign set_n = ~((load_i & load_data_i) | (~load_i & preset_i));
  assign rst_n = nrst_i & ~((load_i & ~load_data_i) | (~load_i & ~preset_i & clear_i));

  // rising edge of the selected clock only
  always_ff @(posedge cell_clk_i or negedge set_n or negedge rst_n) begin
    if (!rst_n) begin
      q_o <= CELL_RESET;
    end else if (!set_n) begin
      q_o <= 1'b1;
    end else begin
      q_o <= next_i;
    end
  end
endmodule : lgc_cell_ff

// File: core/lgc_output_cells.sv
`timescale 1ns/1ps
module lgc_output_cells
  import lgc_pkg::*;
#(
  parameter int CELLS = NUM_OUT_CELLS,
  parameter int TERMS = MAX_PRODUCT_TERMS,
  parameter bit LARGE_PACKAGE = 1'b1
)(
  // system
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // common clock pin (asynchronous to clk_i)
  input wire logic port_d_pin_one_i,
  // product terms from the and array
  input wire logic [TERMS-1:0] product_term_i,
  // per-cell configuration (static personality)
  input wire logic [CELLS*8-1:0] term_sel_i,
  input wire logic [CELLS*8-1:0] clk_term_sel_i,
  input wire logic [CELLS*8-1:0] preset_term_sel_i,
  input wire logic [CELLS*8-1:0] clear_term_sel_i,
  input wire logic [CELLS-1:0] borrow_en_i,
  input wire logic [CELLS-1:0] common_clk_sel_i,
  input wire logic [CELLS-1:0] polarity_i,
  input wire logic [CELLS-1:0] registered_i,
  input wire logic [CELLS*2-1:0] ff_kind_i,
  input wire logic [CELLS-1:0] route_alt_i,
  input wire logic [CELLS-1:0] route_en_i,
  // processor data bus load / read
  input wire logic load_first_i,
  input wire logic load_second_i,
  input wire logic [7:0] data_i,
  input wire logic [7:0] mask_first_i,
  input wire logic [7:0] mask_second_i,
  // outputs
  output logic [7:0] read_first_o,
  output logic [7:0] read_second_o,
  output logic [CELLS-1:0] feedback_o,
  output logic [7:0] port_a_o,
  output logic [7:0] port_b_o,
  output logic [7:0] port_c_o
);
  localparam int BANK = BANK_WIDTH;

  // common clock pin synchroniser; first stage read only by the second
  logic pin_clk_meta;
  logic pin_clk_sync;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_clk_meta <= 1'b0;
      pin_clk_sync <= 1'b0;
    end else if (ce_i) begin
      pin_clk_meta <= port_d_pin_one_i;
      pin_clk_sync <= pin_clk_meta;
    end
  end

  // per-cell combinational results
  logic [CELLS-1:0] sum_term;
  logic [CELLS-1:0] xor_out;
  logic [CELLS-1:0] ff_q;
  logic [CELLS-1:0] cell_out;
  logic [CELLS-1:0] term_clk;
  logic [CELLS-1:0] term_pre;
  logic [CELLS-1:0] term_clr;

  genvar g;
  generate
    for (g = 0; g < CELLS; g++) begin : g_cell
      // bank index n and bank membership
      localparam bit SECOND = (g >= BANK);
      localparam int IDX = g % BANK;
      localparam int NATIVE = SECOND ? SECOND_NATIVE_TERMS : FIRST_NATIVE_TERMS;
      localparam int BORROW = !SECOND ? FIRST_BORROW_TERMS :
                              (IDX < SECOND_LOW_CELLS ? SECOND_LOW_BORROW_TERMS : SECOND_HIGH_BORROW_TERMS);
      // terms owned by this cell: a fixed slice, natives first
      localparam int BASE = (g * MAX_CELL_TERMS) % TERMS;
      localparam int NBR = ((g + 1) % CELLS) * MAX_CELL_TERMS % TERMS;
      logic [7:0] sel;
      logic [MAX_CELL_TERMS-1:0] avail;
      logic sel_clk;
      logic next_q;
      logic j_in;
      logic k_in;
      logic [7:0] ti;
      logic [7:0] pi;
      logic [7:0] ci;
      assign sel = term_sel_i[g*8 +: 8];
      assign ti = clk_term_sel_i[g*8 +: 8];
      assign pi = preset_term_sel_i[g*8 +: 8];
      assign ci = clear_term_sel_i[g*8 +: 8];

      // native terms plus terms borrowed from the neighbour; the neighbour
      // lends only when it does not itself use them, and borrowing is pure
      // or-gating so no stage is added
      always_comb begin
        avail = '0;
        for (int k = 0; k < NATIVE; k++) begin
          avail[k] = product_term_i[(BASE + k) % TERMS] & sel[k];
        end
        for (int k = 0; k < BORROW; k++) begin
          avail[NATIVE + k] = product_term_i[(NBR + k) % TERMS] & borrow_en_i[g]
                              & ~borrow_en_i[(g + 1) % CELLS] & ~term_sel_i[((g + 1) % CELLS) * 8 + k];
        end
      end
      assign sum_term[g] = |avail;

      // polarity stage
      assign xor_out[g] = sum_term[g] ^ polarity_i[g];

      // dedicated clock, preset, clear terms
      assign term_clk[g] = product_term_i[ti % TERMS];
      assign term_pre[g] = product_term_i[pi % TERMS];
      assign term_clr[g] = product_term_i[ci % TERMS];
      // common clock from the synchronised pin, else own term
      assign sel_clk = common_clk_sel_i[g] ? pin_clk_sync : term_clk[g];

      // flip-flop personality: t toggles, jk uses sum/polarity as j/k
      assign j_in = sum_term[g];
      assign k_in = polarity_i[g];
      always_comb begin
        case (lgc_ff_type'(ff_kind_i[g*2 +: 2]))
          LGC_FF_D: next_q = xor_out[g];
          LGC_FF_T: next_q = ff_q[g] ^ xor_out[g];
          LGC_FF_JK: next_q = (j_in & ~ff_q[g]) | (~k_in & ff_q[g]);
          LGC_FF_SR: next_q = j_in | (ff_q[g] & ~k_in);
          default: next_q = xor_out[g];
        endcase
      end

      // processor load gated by mask bit, bit n of the bus for cell n
      logic load_hit;
      assign load_hit = (SECOND ? load_second_i & ~mask_second_i[IDX]
                                : load_first_i & ~mask_first_i[IDX]);

      lgc_cell_ff u_ff (
        .cell_clk_i(sel_clk),
        .nrst_i(nrst_i),
        .preset_i(term_pre[g]),
        .clear_i(term_clr[g]),
        .load_i(load_hit),
        .load_data_i(data_i[IDX]),
        .next_i(next_q),
        .q_o(ff_q[g])
      );

      // output multiplexer
      assign cell_out[g] = registered_i[g] ? ff_q[g] : xor_out[g];
    end
  endgenerate

  // feedback, bus read and pin drive all come from the same cell output
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      feedback_o <= '0;
      read_first_o <= 8'h00;
      read_second_o <= 8'h00;
    end else if (ce_i) begin
      feedback_o <= cell_out;
      read_first_o <= cell_out[BANK-1:0];
      read_second_o <= cell_out[CELLS-1:BANK];
    end
  end

  // allocator: one pin per cell; first bank a or b, second bank b or c
  logic [7:0] next_port_a;
  logic [7:0] next_port_b;
  logic [7:0] next_port_c;
  always_comb begin
    next_port_a = 8'h00;
    next_port_b = 8'h00;
    next_port_c = 8'h00;
    for (int n = 0; n < BANK; n++) begin
      // first bank: alt selects port a, only when the large package has it
      if (route_en_i[n]) begin
        if (route_alt_i[n] && LARGE_PACKAGE) begin
          next_port_a[n] = cell_out[n];
        end else if (!route_alt_i[n]) begin
          next_port_b[n] = cell_out[n];
        end
      end
      // second bank: alt selects port c except on test pins; when both banks
      // claim port b bit n the first bank keeps it, the second is dropped
      if (route_en_i[BANK+n]) begin
        if (route_alt_i[BANK+n] && !PORT_C_BARRED[n]) begin
          next_port_c[n] = cell_out[BANK+n];
        end else if (!route_alt_i[BANK+n] && !(route_en_i[n] && !route_alt_i[n])) begin
          next_port_b[n] = cell_out[BANK+n];
        end
      end
    end
  end

  // pin registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port_a_o <= 8'h00;
      port_b_o <= 8'h00;
      port_c_o <= 8'h00;
    end else if (ce_i) begin
      port_a_o <= next_port_a;
      port_b_o <= next_port_b;
      port_c_o <= next_port_c;
    end
  end

  // checks: every property samples on clk_i; asynchronous cell events are
  // judged by the level they leave behind at the next edge, not by timing
  // inside the cycle, so these do not pin down propagation delay
  // cell 0 and cell 15 stand for their banks; all cells come from one
  // generate loop, so a fault in one cell shows in every cell of its bank with the same borrow count

  // named steps shared by several checks
  // an unmasked processor load of first-bank cell 0 while it is registered
  sequence seq_load_first0;
    ce_i && load_first_i && !mask_first_i[0] && registered_i[0];
  endsequence

  // a masked load of first-bank cell 0 starting at this edge, with nothing
  // else (clock term, common clock, preset, clear) able to move the flop
  sequence seq_masked_first0;
    $rose(load_first_i) && mask_first_i[0] && registered_i[0] && !common_clk_sel_i[0] &&
      !term_pre[0] && !term_clr[0] && $stable(term_clk[0]);
  endsequence

  // first-bank cell 0 routed to its port b pin
  sequence seq_first0_on_b;
    ce_i && route_en_i[0] && !route_alt_i[0];
  endsequence

  // first-bank cell 0 routed to its port a pin, large package only
  sequence seq_first0_on_a;
    ce_i && LARGE_PACKAGE && route_en_i[0] && route_alt_i[0];
  endsequence

  // the test access pins of port c are never driven
  AST_PORT_C_BARRED: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (port_c_o & PORT_C_BARRED) == 8'h00) else $error("test pins driven");

  // the small package has no port a at all
  AST_NO_PORT_A_SMALL: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !LARGE_PACKAGE |-> port_a_o == 8'h00) else $error("port a on small package");

  // feedback follows the multiplexer one clock later
  AST_FEEDBACK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i |=> feedback_o == $past(cell_out)) else $error("feedback mismatch");

  // bank cell n lands on bus bit n of its bank byte
  AST_READ_BITS: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i |=> {read_second_o, read_first_o} == $past(cell_out)) else $error("bus bit order");

  // a cell routed to port b leaves its port a pin alone
  AST_ONE_PIN: assert property (@(posedge clk_i) disable iff (!nrst_i)
    seq_first0_on_b |=> port_a_o[0] == 1'b0) else $error("cell on two pins");

  // bypass path carries the polarity stage straight through
  AST_COMB_PATH: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !registered_i[0] |-> cell_out[0] == (sum_term[0] ^ polarity_i[0])) else $error("comb path");

  // polarity set inverts the sum
  AST_POLARITY: assert property (@(posedge clk_i) disable iff (!nrst_i)
    polarity_i[0] |-> xor_out[0] != sum_term[0]) else $error("polarity");

  // an unmasked load is visible at once, whatever the array does
  AST_MASK_LOAD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    load_first_i && !mask_first_i[0] && registered_i[0] |-> cell_out[0] == data_i[0])
    else $error("unmasked load lost");

  // a level preset holds the flop high while no load is running
  AST_PRESET: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !load_first_i && term_pre[0] && registered_i[0] |-> cell_out[0]) else $error("preset ignored");

  // a level clear holds the flop low when preset is idle; preset wins a tie
  AST_CLEAR: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !load_first_i && !term_pre[0] && term_clr[0] && registered_i[0] |-> !cell_out[0]) else $error("clear ignored");

  // a masked load leaves the cell exactly as it was
  AST_MASK_BLOCK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    seq_masked_first0 |-> $stable(cell_out[0])) else $error("masked load got through");

  // the loaded bit reads back on its own data bit one clock later
  AST_LOAD_READBACK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    seq_load_first0 |=> read_first_o[0] == $past(data_i[0])) else $error("load readback");

  // second bank loads use the same bit order, top cell on the top bit
  AST_SECOND_LOAD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    load_second_i && !mask_second_i[7] && registered_i[15] |-> cell_out[15] == data_i[7])
    else $error("second bank load bit");

  // port b pin shows the first-bank cell one clock later
  AST_FIRST_ON_B: assert property (@(posedge clk_i) disable iff (!nrst_i)
    seq_first0_on_b |=> port_b_o[0] == $past(cell_out[0])) else $error("port b drive");

  // port a pin shows the first-bank cell one clock later
  AST_FIRST_ON_A: assert property (@(posedge clk_i) disable iff (!nrst_i)
    seq_first0_on_a |=> port_a_o[0] == $past(cell_out[0])) else $error("port a drive");

  // a second-bank cell on a free port c pin drives it
  AST_SECOND_ON_C: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && route_en_i[15] && route_alt_i[15] |=> port_c_o[7] == $past(cell_out[15])) else $error("port c drive");

  // buried cells leave their pins low
  AST_UNROUTED: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && !route_en_i[0] && !route_en_i[8] |=> !port_a_o[0] && !port_b_o[0]) else $error("buried cell on pin");

  // the common clock moves from the first synchroniser stage to the second one clock later
  AST_PIN_SYNC: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i |=> pin_clk_sync == $past(pin_clk_meta)) else $error("pin clock sync");

  // a borrowed term that the lender leaves unused reaches the sum directly
  AST_BORROW: assert property (@(posedge clk_i) disable iff (!nrst_i)
    borrow_en_i[3] && !borrow_en_i[4] && !term_sel_i[32] && !registered_i[3] && !polarity_i[3] &&
    product_term_i[40] |-> cell_out[3]) else $error("borrowed term lost");

  // in bypass the feedback carries the polarity stage, not the flop
  AST_COMB_FB: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && !registered_i[0] |=> feedback_o[0] == $past(xor_out[0])) else $error("comb feedback");
endmodule : lgc_output_cells

// File: tb/lgc_array_model.sv
`timescale 1ns/1ps
// stand-in for the and array: each product term holds its level until told
module lgc_array_model
  import lgc_pkg::*;
(
  // system
  input wire logic clk_i,
  input wire logic nrst_i,
  // term update request
  input wire logic wr_i,
  input wire logic [7:0] idx_i,
  input wire logic val_i,
  // product terms
  output logic [MAX_PRODUCT_TERMS-1:0] term_o
);
  // terms move only on request, so the cells see clean single edges
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      term_o <= '0;
    end else if (wr_i) begin
      term_o[idx_i] <= val_i;
    end
  end
endmodule : lgc_array_model

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import lgc_pkg::*;
  logic clk_i, nrst_i, pin, wr, val, ld1, ld2;
  logic [7:0] idx, data, m1, m2, r1, r2, pa, pb, pc;
  logic [MAX_PRODUCT_TERMS-1:0] pt;
  // index 136 is never raised, so it serves as a dead term
  logic [127:0] ts, cs, ps, xs;
  logic [15:0] com, pol, rq, alt, ren, fb, bo;
  logic [31:0] ks;
  int failures, checks_done, cycles;
  lgc_array_model u_lgc_array_model(.clk_i(clk_i), .nrst_i(nrst_i), .wr_i(wr),
    .idx_i(idx), .val_i(val), .term_o(pt));
  lgc_output_cells u_lgc_output_cells(.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
    .port_d_pin_one_i(pin), .product_term_i(pt), .term_sel_i(ts), .clk_term_sel_i(cs),
    .preset_term_sel_i(ps), .clear_term_sel_i(xs), .borrow_en_i(bo),
    .common_clk_sel_i(com), .polarity_i(pol), .registered_i(rq), .ff_kind_i(ks),
    .route_alt_i(alt), .route_en_i(ren), .load_first_i(ld1), .load_second_i(ld2),
    .data_i(data), .mask_first_i(m1), .mask_second_i(m2), .read_first_o(r1),
    .read_second_o(r2), .feedback_o(fb), .port_a_o(pa), .port_b_o(pb), .port_c_o(pc));
  always #5 clk_i = ~clk_i;
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  task wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wt
  // one product term change, through the array model
  task term(input int i, input logic v);
    @(negedge clk_i);
    wr = 1'b1;
    idx = i[7:0];
    val = v;
    @(negedge clk_i);
    wr = 1'b0;
  endtask : term
  // processor load of one bank; masks stay as given until the next load
  // the strobe stands a whole clock, a wait state's worth for slow selects
  task load(input bit second, input logic [7:0] d, input logic [7:0] m);
    @(negedge clk_i);
    data = d;
    m1 = m;
    m2 = m;
    ld1 = !second;
    ld2 = second;
    @(negedge clk_i);
    ld1 = 1'b0;
    ld2 = 1'b0;
    wt(2);
  endtask : load
  task t_reset;
    chk("cells", 16'h0, {r2, r1});
    chk("ports", 16'h0, {pa, pb | pc});
  endtask : t_reset
  task t_load;
    load(0, 8'h55, 8'h00);
    chk("first", 16'h55, {8'h0, r1});
    load(1, 8'ha3, 8'h00);
    chk("second", 16'ha3, {8'h0, r2});
    chk("feedback", 16'ha355, fb);
  endtask : t_load
  task t_mask;
    load(0, 8'hff, 8'h0f);
    chk("mask1", 16'hf5, {8'h0, r1});
    load(1, 8'h00, 8'hf0);
    chk("mask2", 16'ha0, {8'h0, r2});
  endtask : t_mask
  // cell 3 borrows term 40 from cell 4, then loses it once cell 4 uses it
  task t_borrow;
    rq[3] = 1'b0;
    bo[3] = 1'b1;
    term(40, 1'b1);
    wt(2);
    chk("borrow", 16'h1, {15'h0, r1[3]});
    ts[32] = 1'b1;
    wt(2);
    chk("lend_stop", 16'h0, {15'h0, r1[3]});
    term(40, 1'b0);
    ts[32] = 1'b0;
    bo[3] = 1'b0;
    rq[3] = 1'b1;
  endtask : t_borrow
  task t_route;
    @(negedge clk_i);
    ren = 16'hffff;
    alt = 16'hffff;
    wt(2);
    chk("port_a", 16'hf5, {8'h0, pa});
    chk("port_c", 16'h80, {8'h0, pc});
    alt = 16'h0;
    wt(2);
    chk("port_b", 16'hf5, {8'h0, pb});
    chk("port_ac", 16'h0, {pa, pc});
    ren = 16'h0;
  endtask : t_route
  task t_prclr;
    load(0, 8'h00, 8'h00);
    ps[7:0] = 8'h05;
    xs[7:0] = 8'h06;
    term(5, 1'b1);
    wt(2);
    chk("preset", 16'h1, {15'h0, r1[0]});
    term(5, 1'b0);
    term(6, 1'b1);
    wt(2);
    chk("clear", 16'h0, {15'h0, r1[0]});
    term(6, 1'b0);
  endtask : t_prclr
  task t_dclk;
    ts[0] = 1'b1;
    cs[7:0] = 8'h07;
    term(0, 1'b1);
    wt(2);
    chk("no_edge", 16'h0, {15'h0, r1[0]});
    term(7, 1'b1);
    wt(2);
    chk("d_edge", 16'h1, {15'h0, r1[0]});
    term(7, 1'b0);
  endtask : t_dclk
  task t_comb;
    rq[0] = 1'b0;
    pol[0] = 1'b1;
    wt(2);
    chk("comb_inv", 16'h0, {15'h0, r1[0]});
    term(0, 1'b0);
    wt(2);
    chk("comb_one", 16'h1, {15'h0, fb[0]});
    rq[0] = 1'b1;
  endtask : t_comb
  task t_common;
    load(0, 8'h00, 8'h00);
    ts[8] = 1'b1;
    com[1] = 1'b1;
    term(10, 1'b1);
    pin = 1'b1;
    wt(5);
    chk("pin_clk", 16'h1, {15'h0, r1[1]});
    pin = 1'b0;
  endtask : t_common
  task t_toggle;
    ks[5:4] = 2'b01;
    ts[16] = 1'b1;
    cs[23:16] = 8'h08;
    term(20, 1'b1);
    for (int k = 0; k < 2; k++) begin
      term(8, 1'b1);
      term(8, 1'b0);
      wt(2);
      chk("toggle", {15'h0, k == 0}, {15'h0, r1[2]});
    end
  endtask : t_toggle
  initial begin
    clk_i = 0;
    nrst_i = 0;
    {pin, wr, val, ld1, ld2, idx, data, m1, m2} = '0;
    ts = '0;
    cs = {16{8'h88}};
    ps = {16{8'h88}};
    xs = {16{8'h88}};
    {com, pol, alt, ren, ks, bo} = '0;
    rq = 16'hffff;
    repeat (6) @(negedge clk_i);
    nrst_i = 1;
    wt(2);
    t_reset();
    t_load();
    t_mask();
    t_route();
    t_prclr();
    t_dclk();
    t_comb();
    t_common();
    t_toggle();
    t_borrow();
    conclude();
  end
endmodule : tb
